// >>> hdl/csrf_core.sv
// cpu state: register file, status word, prefetch queue and instruction cache
`timescale 1ns/1ps
`default_nettype none
module csrf_core #(
    parameter int QUEUE_BYTES = 8,
    parameter int CACHE_WORDS = 64
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic coreWrEn,
    input wire logic [4:0] coreWrIdx,
    input wire logic [31:0] coreWrData,
    input wire logic [4:0] coreRdIdx,
    output logic [31:0] coreRdData,
    output logic privViolation,
    input wire logic [4:0] operandIdx,
    input wire logic operandDirect,
    output logic operandIllegal,
    input wire logic [31:0] extIn,
    input wire logic [1:0] extSize,
    input wire logic extSigned,
    output logic [31:0] extOut,
    input wire logic [1:0] accSize,
    input wire logic [1:0] accAddrLow,
    output logic alignFault,
    input wire logic flagsValid,
    input wire logic [3:0] flagsIn,
    input wire logic decimalValid,
    input wire logic decimalCarry,
    input wire logic overflowTrapTaken,
    input wire logic instrStart,
    input wire logic instrEnd,
    output logic traceTrap,
    input wire logic contextSwitch,
    input wire logic contextSaveRegs,
    input wire logic processLoad,
    input wire logic blockMoveActive,
    output logic saveExtraRegs,
    output logic exceptionSwitch,
    output logic initialContext,
    input wire logic excValid,
    input wire logic [1:0] excClass,
    input wire logic [3:0] excSubcode,
    input wire logic [3:0] irqLevel,
    input wire logic irqNonMaskable,
    output logic irqAccept,
    output logic irqFullSwitch,
    output logic overflowTrapEnable,
    input wire logic fetchValid,
    input wire logic fetchFromMem,
    input wire logic [31:0] fetchAddr,
    input wire logic [31:0] fetchWord,
    output logic fetchReady,
    input wire logic [31:0] lookupAddr,
    output logic lookupHit,
    output logic [31:0] lookupWord,
    input wire logic queuePop,
    output logic queueValid,
    output logic [7:0] queueByte
);
    localparam int QPW = $clog2(QUEUE_BYTES);
    localparam int CIW = $clog2(CACHE_WORDS);
    localparam int TAGW = 30 - CIW;

    logic [31:0] regs_q [32];
    logic [31:0] psw_q, psw_d;
    logic [7:0] qMem_q [QUEUE_BYTES];
    logic [QPW-1:0] qHead_q, qTail_q;
    logic [QPW:0] qCount_q;
    logic [31:0] cData_q [CACHE_WORDS];
    logic [TAGW-1:0] cTag_q [CACHE_WORDS];
    logic [CACHE_WORDS-1:0] cValid_q;
    csrf_pkg::csrf_phase_t phase_q;
    logic apbWrite, apbRegHit, apbStatHit, apbDenied;
    logic coreDenied, kernelNow, qPush, qPopDo, cacheFill;
    logic apbFault;
    logic [4:0] apbIdx;
    logic [CIW-1:0] fillIdx, lookIdx;

    function automatic logic privileged(input logic [4:0] idx);
        privileged = (idx >= csrf_pkg::IDX_KERNEL_LO) || (idx == csrf_pkg::IDX_PSW) ||
                     (idx == csrf_pkg::IDX_PCB) || (idx == csrf_pkg::IDX_ISP);
    endfunction

    function automatic logic [31:0] readReg(input logic [4:0] idx, input logic [31:0] r, input logic [31:0] p);
        readReg = (idx == csrf_pkg::IDX_PSW) ? {2'b00, p[29:0]} : r;
    endfunction

    // level zero is kernel
    assign kernelNow = psw_q[csrf_pkg::CURRENT_LEVEL_LO +: 2] == csrf_pkg::LEVEL_KERNEL;
    assign apbIdx = paddr[6:2];
    assign apbRegHit = paddr[7] == 1'b0 && paddr[1:0] == 2'b00;
    assign apbStatHit = paddr == csrf_pkg::STAT_OFS;
    // core writes take the register port first, so the bus waits
    assign pready = phase_q == csrf_pkg::CSRF_ACCESS && !coreWrEn;
    assign apbDenied = apbRegHit && pwrite && privileged(apbIdx) && !kernelNow;
    assign apbFault = pready && apbDenied;
    assign pslverr = pready && (!(apbRegHit || apbStatHit) || (apbStatHit && pwrite) || apbDenied);
    assign apbWrite = pready && pwrite && apbRegHit && !apbDenied;
    assign coreDenied = coreWrEn && privileged(coreWrIdx) && !kernelNow;

    // apb phase tracking
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= csrf_pkg::CSRF_IDLE;
        end else begin
            case (phase_q)
                csrf_pkg::CSRF_IDLE: phase_q <= psel ? csrf_pkg::CSRF_SETUP : csrf_pkg::CSRF_IDLE;
                csrf_pkg::CSRF_SETUP: phase_q <= (psel && penable) ? csrf_pkg::CSRF_ACCESS : phase_q;
                csrf_pkg::CSRF_ACCESS: begin
                    if (pready) begin
                        phase_q <= csrf_pkg::CSRF_IDLE;
                    end
                end
                default: phase_q <= csrf_pkg::CSRF_IDLE;
            endcase
        end
    end

    // read data is captured in setup and held through the access phase
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (phase_q == csrf_pkg::CSRF_SETUP) begin
            if (apbRegHit) begin
                prdata <= readReg(apbIdx, regs_q[apbIdx], psw_q);
            end else if (apbStatHit) begin
                prdata <= 32'(qCount_q);
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // general registers; r11 lives in the status word below
    generate
        for (genvar i = 0; i < 32; i++) begin : g_reg
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    regs_q[i] <= csrf_pkg::REG_RESET;
                end else if (coreWrEn && !coreDenied && coreWrIdx == 5'(i)) begin
                    regs_q[i] <= coreWrData;
                end else if (!coreWrEn && apbWrite && apbIdx == 5'(i)) begin
                    regs_q[i] <= pwdata;
                end
            end
        end
    endgenerate

    // one-cycle pulse per refused write, from the core or the bus
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            coreRdData <= 32'h00000000;
            privViolation <= 1'b0;
        end else begin
            coreRdData <= readReg(coreRdIdx, regs_q[coreRdIdx], psw_q);
            privViolation <= coreDenied || apbFault;
        end
    end

    // status word: software write first, then hardware events override it
    always_comb begin
        psw_d = psw_q;
        if (coreWrEn && !coreDenied && coreWrIdx == csrf_pkg::IDX_PSW) begin
            psw_d = (psw_q & ~csrf_pkg::PSW_SW_MASK) | (coreWrData & csrf_pkg::PSW_SW_MASK);
        end else if (!coreWrEn && apbWrite && apbIdx == csrf_pkg::IDX_PSW) begin
            psw_d = (psw_q & ~csrf_pkg::PSW_SW_MASK) | (pwdata & csrf_pkg::PSW_SW_MASK);
        end
        if (flagsValid) begin
            psw_d[csrf_pkg::FLAGS_LO +: 4] = flagsIn;
        end
        if (decimalValid) begin
            psw_d[csrf_pkg::DECIMAL_CARRY] = decimalCarry;
        end
        if (overflowTrapTaken) begin
            psw_d[csrf_pkg::OVERFLOW_TRAP_ENABLE] = 1'b0;
        end
        if (instrStart) begin
            psw_d[csrf_pkg::TRACE_SUPPRESS] = 1'b1;
        end
        if (contextSwitch) begin
            psw_d[csrf_pkg::SAVE_REGS] = contextSaveRegs;
        end
        if (coreDenied || apbFault) begin
            psw_d[csrf_pkg::CLASS_LO +: 2] = csrf_pkg::CSRF_CLASS_NORMAL;
            psw_d[csrf_pkg::SUBCODE_LO +: 4] = csrf_pkg::SUBCODE_PRIV_REG;
        end else if (excValid) begin
            psw_d[csrf_pkg::CLASS_LO +: 2] = excClass;
            psw_d[csrf_pkg::SUBCODE_LO +: 4] = excSubcode;
        end
        // a switch or fault wins over the start-of-instruction set
        if (contextSwitch || excValid || coreDenied || apbFault) begin
            psw_d[csrf_pkg::TRACE_SUPPRESS] = 1'b0;
        end
        // forced last, so no event or write can ever set the spare bits
        psw_d[31:30] = 2'b00;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            psw_q <= csrf_pkg::PSW_RESET;
        end else begin
            psw_q <= psw_d;
        end
    end

    // operand and width checks
    assign operandIllegal = !operandDirect && (operandIdx == csrf_pkg::IDX_PC ||
                            operandIdx == csrf_pkg::IDX_PSW);
    assign alignFault = !psw_q[csrf_pkg::UNALIGNED_ACCESS_ENABLE] &&
                        ((accSize == csrf_pkg::CSRF_SIZE_HALF && accAddrLow[0]) ||
                         (accSize == csrf_pkg::CSRF_SIZE_WORD && accAddrLow != 2'b00));

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            extOut <= 32'h00000000;
        end else begin
            // word size and the unused code pass the value through
            case (extSize)
                csrf_pkg::CSRF_SIZE_BYTE: extOut <= {{24{extSigned & extIn[7]}}, extIn[7:0]};
                csrf_pkg::CSRF_SIZE_HALF: extOut <= {{16{extSigned & extIn[15]}}, extIn[15:0]};
                default: extOut <= extIn;
            endcase
        end
    end

    // mode outputs driven from status word
    assign exceptionSwitch = psw_q[csrf_pkg::SWITCH_ON_EXCEPTION];
    assign saveExtraRegs = psw_q[csrf_pkg::EXTRA_SAVE_ENABLE] && !blockMoveActive;
    assign overflowTrapEnable = psw_q[csrf_pkg::OVERFLOW_TRAP_ENABLE];
    assign traceTrap = instrEnd && psw_q[csrf_pkg::TRACE_ON] && !psw_q[csrf_pkg::TRACE_SUPPRESS];
    assign initialContext = psw_q[csrf_pkg::INITIAL_CONTEXT];
    // equal level is refused, so 1111 masks everything maskable
    assign irqAccept = irqNonMaskable || (irqLevel > psw_q[csrf_pkg::THRESHOLD_LO +: 4]);
    assign irqFullSwitch = irqAccept && !psw_q[csrf_pkg::FAST_INTERRUPT_ENABLE];

    // prefetch queue: a whole word enters only when four bytes are free
    assign fetchReady = (QUEUE_BYTES - int'(qCount_q)) >= int'(csrf_pkg::QUEUE_ROOM_FOR_WORD);
    assign qPush = fetchValid && fetchReady;
    assign qPopDo = queuePop && queueValid;
    assign queueValid = qCount_q != '0;
    assign queueByte = qMem_q[qHead_q];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            qHead_q <= '0;
            qTail_q <= '0;
            qCount_q <= '0;
        end else begin
            if (qPopDo) begin
                qHead_q <= qHead_q + 1'b1;
            end
            if (qPush) begin
                qTail_q <= qTail_q + QPW'(4);
            end
            qCount_q <= qCount_q + (qPush ? (QPW+1)'(4) : '0) - (qPopDo ? (QPW+1)'(1) : '0);
        end
    end

    // each slot has a single writer, picked by its distance from the tail
    generate
        for (genvar s = 0; s < QUEUE_BYTES; s++) begin : g_qbyte
            logic [QPW-1:0] lane;
            assign lane = QPW'(s) - qTail_q;
            always_ff @(posedge clk_sys) begin
                if (qPush && lane < QPW'(4)) begin
                    qMem_q[s] <= fetchWord[8*lane +: 8];
                end
            end
        end
    endgenerate

    // direct-mapped instruction cache
    assign fillIdx = fetchAddr[2 +: CIW];
    assign lookIdx = lookupAddr[2 +: CIW];
    assign cacheFill = qPush && fetchFromMem && !psw_q[csrf_pkg::ICACHE_DISABLE];

    // data and tags carry no reset: a clear valid bit blocks a hit on them
    always_ff @(posedge clk_sys) begin
        if (cacheFill) begin
            cData_q[fillIdx] <= fetchWord;
            cTag_q[fillIdx] <= fetchAddr[31:2+CIW];
        end
    end

    // a flush beats a same-cycle fill, so no line of the old process survives
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cValid_q <= '0;
        end else if (processLoad && !psw_q[csrf_pkg::KEEP_ICACHE_ON_SWITCH]) begin
            cValid_q <= '0;
        end else if (cacheFill) begin
            cValid_q[fillIdx] <= 1'b1;
        end
    end

    // lookup answers one cycle later; a disabled cache never hits
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lookupHit <= 1'b0;
            lookupWord <= 32'h00000000;
        end else begin
            lookupHit <= cValid_q[lookIdx] && cTag_q[lookIdx] == lookupAddr[31:2+CIW] &&
                         !psw_q[csrf_pkg::ICACHE_DISABLE];
            lookupWord <= cData_q[lookIdx];
        end
    end
endmodule
`default_nettype wire

// >>> hdl/csrf_pkg.sv
// constants and types for the cpu status register file
package csrf_pkg;
    // apb map: r0..r31 at word addresses, then a read-only prefetch queue byte count
    localparam logic [7:0] REGS_BASE = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h80;
    // register indices with special handling
    localparam logic [4:0] IDX_FRAME_BASE = 5'h09;
    localparam logic [4:0] IDX_ARGUMENT_BASE = 5'h0A;
    localparam logic [4:0] IDX_PSW = 5'h0B;
    localparam logic [4:0] IDX_PCB = 5'h0D;
    localparam logic [4:0] IDX_ISP = 5'h0E;
    localparam logic [4:0] IDX_PC = 5'h0F;
    localparam logic [4:0] IDX_KERNEL_LO = 5'h18;
    // status word field positions
    localparam int UNALIGNED_ACCESS_ENABLE = 29;
    localparam int SWITCH_ON_EXCEPTION = 28;
    localparam int EXTRA_SAVE_ENABLE = 27;
    localparam int DECIMAL_CARRY = 26;
    localparam int KEEP_ICACHE_ON_SWITCH = 25;
    localparam int FAST_INTERRUPT_ENABLE = 24;
    localparam int ICACHE_DISABLE = 23;
    localparam int OVERFLOW_TRAP_ENABLE = 22;
    localparam int FLAGS_LO = 18;
    localparam int TRACE_ON = 17;
    localparam int THRESHOLD_LO = 13;
    localparam int CURRENT_LEVEL_LO = 11;
    localparam int PREVIOUS_LEVEL_LO = 9;
    localparam int SAVE_REGS = 8;
    localparam int INITIAL_CONTEXT = 7;
    localparam int SUBCODE_LO = 3;
    localparam int TRACE_SUPPRESS = 2;
    localparam int CLASS_LO = 0;
    // bits that software may change: not 31:30, 26, 8, 2
    localparam logic [31:0] PSW_SW_MASK = 32'h3BFFFEFB;
    // after reset: class reset, subcode external reset
    localparam logic [31:0] PSW_RESET = 32'h00000018;
    localparam logic [31:0] REG_RESET = 32'h00000000;
    localparam logic [3:0] SUBCODE_PRIV_REG = 4'hF;
    localparam logic [3:0] THRESHOLD_ALL_MASKED = 4'hF;
    localparam logic [1:0] LEVEL_KERNEL = 2'h0;
    localparam logic [3:0] QUEUE_ROOM_FOR_WORD = 4'h4;
    typedef enum logic [1:0] {
        CSRF_CLASS_RESET = 2'h0,
        CSRF_CLASS_PROCESS = 2'h1,
        CSRF_CLASS_STACK = 2'h2,
        CSRF_CLASS_NORMAL = 2'h3
    } csrf_class_t;
    typedef enum logic [1:0] {
        CSRF_SIZE_BYTE = 2'h0,
        CSRF_SIZE_HALF = 2'h1,
        CSRF_SIZE_WORD = 2'h2
    } csrf_size_t;
    // apb transfer phases, gray along idle, setup, access
    typedef enum logic [1:0] {
        CSRF_IDLE = 2'h0,
        CSRF_SETUP = 2'h1,
        CSRF_ACCESS = 2'h3
    } csrf_phase_t;
endpackage

// >>> verification/csrf_core_chk.sv
// concurrent checks on the core's control and widening outputs
`timescale 1ns/1ps
`default_nettype none
module csrf_core_chk (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [4:0] operandIdx,
    input wire logic operandDirect,
    input wire logic operandIllegal,
    input wire logic instrEnd,
    input wire logic traceTrap,
    input wire logic irqNonMaskable,
    input wire logic irqAccept,
    input wire logic irqFullSwitch,
    input wire logic blockMoveActive,
    input wire logic saveExtraRegs,
    input wire logic overflowTrapTaken,
    input wire logic overflowTrapEnable,
    input wire logic [1:0] accSize,
    input wire logic [1:0] accAddrLow,
    input wire logic alignFault,
    input wire logic [31:0] extIn,
    input wire logic [1:0] extSize,
    input wire logic extSigned,
    input wire logic [31:0] extOut
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_operand_restrict: assert property (operandIllegal == (!operandDirect &&
        (operandIdx == csrf_pkg::IDX_PC || operandIdx == csrf_pkg::IDX_PSW))) else $error("operand flag wrong");
    a_trace_needs_end: assert property (traceTrap |-> instrEnd)
        else $error("trace trap outside instruction end");
    a_nmi_accepted: assert property (irqNonMaskable |-> irqAccept)
        else $error("nonmaskable request not accepted");
    a_full_needs_accept: assert property (irqFullSwitch |-> irqAccept)
        else $error("full switch without accepted request");
    a_block_move_hold: assert property (blockMoveActive |-> !saveExtraRegs)
        else $error("extra save during block move");
    a_ovf_cleared: assert property (overflowTrapTaken |=> !overflowTrapEnable)
        else $error("overflow enable survived a taken trap");
    a_aligned_no_fault: assert property ((accSize == csrf_pkg::CSRF_SIZE_BYTE || accAddrLow == 2'h0)
        |-> !alignFault) else $error("fault on an aligned access");
    a_byte_zero_fill: assert property (extSize == csrf_pkg::CSRF_SIZE_BYTE && !extSigned
        |=> extOut == {24'h000000, $past(extIn[7:0])}) else $error("byte not zero filled");
    a_half_sign_fill: assert property (extSize == csrf_pkg::CSRF_SIZE_HALF && extSigned
        |=> extOut == {{16{$past(extIn[15])}}, $past(extIn[15:0])}) else $error("half not sign filled");
endmodule
bind csrf_core csrf_core_chk u_chk (.clk_sys, .sys_rst, .operandIdx, .operandDirect, .operandIllegal, .instrEnd,
    .traceTrap, .irqNonMaskable, .irqAccept, .irqFullSwitch, .blockMoveActive, .saveExtraRegs, .overflowTrapTaken,
    .overflowTrapEnable, .accSize, .accAddrLow, .alignFault, .extIn, .extSize, .extSigned, .extOut);
`default_nettype wire

// >>> verification/csrf_mem_model.sv
// memory side model: answers one instruction fetch at a time, promptly or late
`timescale 1ns/1ps
`default_nettype none
module csrf_mem_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic reqGo,
    input wire logic [31:0] reqAddr,
    input wire logic [31:0] reqWord,
    input wire logic slow,
    input wire logic fetchReady,
    output logic fetchValid,
    output logic fetchFromMem,
    output logic [31:0] fetchAddr,
    output logic [31:0] fetchWord
);
    logic busy_q;
    logic [1:0] waitCnt_q;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            {fetchValid, fetchFromMem, busy_q, waitCnt_q, fetchAddr, fetchWord} <= '0;
        end else if (fetchValid && fetchReady) begin
            // bus released: show junk so a stale word cannot pass for a real one
            {fetchValid, fetchFromMem, busy_q} <= 3'h0;
            {fetchAddr, fetchWord} <= ~{fetchAddr, fetchWord};
        end else if (reqGo && !busy_q) begin
            {busy_q, waitCnt_q} <= {1'h1, slow, 1'h0};
            {fetchAddr, fetchWord} <= {reqAddr, reqWord};
        end else if (busy_q && !fetchValid) begin
            if (waitCnt_q == 2'h0) begin
                {fetchValid, fetchFromMem} <= 2'h3;
            end else begin
                waitCnt_q <= waitCnt_q - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/cpu_status_register_file_tb.sv
// self-checking bench for the cpu status register file
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module cpu_status_register_file_tb;
    logic clk_sys = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, coreWrEn = 1'h0;
    logic operandDirect = 1'h0, extSigned = 1'h0, flagsValid = 1'h0, decimalValid = 1'h0, decimalCarry = 1'h0;
    logic overflowTrapTaken = 1'h0, instrStart = 1'h0, instrEnd = 1'h0, contextSwitch = 1'h0, processLoad = 1'h0;
    logic contextSaveRegs = 1'h0, blockMoveActive = 1'h0, excValid = 1'h0, irqNonMaskable = 1'h0, queuePop = 1'h0;
    logic reqGo = 1'h0, slow = 1'h0, er;
    logic [7:0] paddr = '0, queueByte;
    logic [31:0] pwdata = '0, coreWrData = '0, extIn = '0, lookupAddr = '0, reqAddr = '0, reqWord = '0, rd;
    logic [4:0] coreWrIdx = '0, coreRdIdx = '0, operandIdx = '0;
    logic [1:0] extSize = '0, accSize = '0, accAddrLow = '0, excClass = '0;
    logic [3:0] flagsIn = '0, excSubcode = '0, irqLevel = '0;
    logic [31:0] prdata, coreRdData, extOut, fetchAddr, fetchWord, lookupWord;
    logic pready, pslverr, privViolation, operandIllegal, alignFault, traceTrap, saveExtraRegs, exceptionSwitch;
    logic initialContext, irqAccept, irqFullSwitch, overflowTrapEnable, fetchValid, fetchFromMem, fetchReady;
    logic lookupHit, queueValid;
    int errors = 0;
    int samples_checked = 0;
    csrf_core DUT (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .coreWrEn, .coreWrIdx, .coreWrData, .coreRdIdx, .coreRdData, .privViolation, .operandIdx, .operandDirect,
        .operandIllegal, .extIn, .extSize, .extSigned, .extOut, .accSize, .accAddrLow, .alignFault, .flagsValid,
        .flagsIn, .decimalValid, .decimalCarry, .overflowTrapTaken, .instrStart, .instrEnd, .traceTrap,
        .contextSwitch, .contextSaveRegs, .processLoad, .blockMoveActive, .saveExtraRegs, .exceptionSwitch,
        .initialContext, .excValid, .excClass, .excSubcode, .irqLevel, .irqNonMaskable, .irqAccept, .irqFullSwitch,
        .overflowTrapEnable, .fetchValid, .fetchFromMem, .fetchAddr, .fetchWord, .fetchReady, .lookupAddr,
        .lookupHit, .lookupWord, .queuePop, .queueValid, .queueByte);
    csrf_mem_model MEM (.clk_sys, .sys_rst, .reqGo, .reqAddr, .reqWord, .slow, .fetchReady, .fetchValid,
        .fetchFromMem, .fetchAddr, .fetchWord);
    always #20 clk_sys = ~clk_sys;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x, input logic xe);
        int n = 0;
        @(posedge clk_sys);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        @(posedge clk_sys);
        while (pready !== 1'h1 && n++ < 50) @(posedge clk_sys);
        if (n > 50) errors++;
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        `CHK("pslverr", xe, er)
        if (!w && !xe) `CHK("prdata", x, rd)
    endtask
    task automatic fetch(input logic [31:0] a, input logic [31:0] w, input logic s);
        int n = 0;
        @(posedge clk_sys);
        {reqAddr, reqWord, slow, reqGo} <= {a, w, s, 1'h1};
        @(posedge clk_sys);
        reqGo <= 1'h0;
        while (!(fetchValid === 1'h1 && fetchReady === 1'h1) && n++ < 20) @(posedge clk_sys);
        if (n > 20) errors++;
    endtask
    task automatic t_regs;
        apb(1'h0, 8'h2C, '0, csrf_pkg::PSW_RESET, 1'h0);
        apb(1'h1, 8'h24, 32'hA5A50009, '0, 1'h0);
        apb(1'h0, 8'h24, '0, 32'hA5A50009, 1'h0);
        apb(1'h1, 8'h7C, 32'h0000001F, '0, 1'h0);
        apb(1'h0, 8'h7C, '0, 32'h0000001F, 1'h0);
        apb(1'h0, 8'h84, '0, '0, 1'h1);
        apb(1'h1, 8'h80, 32'h00000001, '0, 1'h1);
    endtask
    task automatic t_psw;
        apb(1'h1, 8'h2C, 32'hFFFFE7FF, '0, 1'h0);
        apb(1'h0, 8'h2C, '0, 32'h3BFFE6FB, 1'h0);
        @(posedge clk_sys);
        {irqLevel, accSize, accAddrLow} <= {4'hF, 2'h2, 2'h1};
        #1;
        `CHK("irqAccept", 1'h0, irqAccept)
        `CHK("alignFault", 1'h0, alignFault)
        `CHK("saveExtraRegs", 1'h1, saveExtraRegs)
        `CHK("exceptionSwitch", 1'h1, exceptionSwitch)
        `CHK("initialContext", 1'h1, initialContext)
        `CHK("overflowTrapEnable", 1'h1, overflowTrapEnable)
        @(posedge clk_sys);
        {irqNonMaskable, blockMoveActive, overflowTrapTaken} <= 3'h7;
        #1;
        `CHK("irqAccept", 1'h1, irqAccept)
        `CHK("irqFullSwitch", 1'h0, irqFullSwitch)
        `CHK("saveExtraRegs", 1'h0, saveExtraRegs)
        @(posedge clk_sys);
        {irqNonMaskable, blockMoveActive, overflowTrapTaken} <= 3'h0;
        #1;
        `CHK("overflowTrapEnable", 1'h0, overflowTrapEnable)
        apb(1'h1, 8'h2C, 32'h0000A000, '0, 1'h0);
        @(posedge clk_sys);
        {irqLevel, accAddrLow} <= {4'h5, 2'h2};
        #1;
        `CHK("irqAccept", 1'h0, irqAccept)
        `CHK("alignFault", 1'h1, alignFault)
        @(posedge clk_sys);
        {irqLevel, accSize, accAddrLow} <= {4'h6, 2'h0, 2'h3};
        #1;
        `CHK("irqFullSwitch", 1'h1, irqFullSwitch)
        @(posedge clk_sys);
        {flagsValid, flagsIn, decimalValid, decimalCarry} <= {1'h1, 4'h9, 2'h3};
        @(posedge clk_sys);
        {flagsValid, decimalValid} <= 2'h0;
        apb(1'h0, 8'h2C, '0, 32'h0424A000, 1'h0);
        @(posedge clk_sys);
        {decimalValid, decimalCarry} <= 2'h2;
        @(posedge clk_sys);
        decimalValid <= 1'h0;
        apb(1'h0, 8'h2C, '0, 32'h0024A000, 1'h0);
        apb(1'h1, 8'h2C, 32'h00020000, '0, 1'h0);
        @(posedge clk_sys);
        instrStart <= 1'h1;
        @(posedge clk_sys);
        {instrStart, instrEnd} <= 2'h1;
        #1;
        `CHK("traceTrap", 1'h0, traceTrap)
        @(posedge clk_sys);
        {instrEnd, contextSwitch} <= 2'h1;
        @(posedge clk_sys);
        {instrEnd, contextSwitch} <= 2'h2;
        #1;
        `CHK("traceTrap", 1'h1, traceTrap)
        @(posedge clk_sys);
        instrEnd <= 1'h0;
    endtask
    task automatic t_fetch;
        fetch(32'h00000040, 32'h44332211, 1'h0);
        fetch(32'h00000044, 32'h88776655, 1'h1);
        @(posedge clk_sys);
        lookupAddr <= 32'h00000040;
        #1;
        `CHK("fetchReady", 1'h0, fetchReady)
        @(posedge clk_sys);
        #1;
        `CHK("lookupHit", 1'h1, lookupHit)
        `CHK("lookupWord", 32'h44332211, lookupWord)
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_sys);
            queuePop <= 1'h1;
            #1;
            `CHK("queueByte", 8'(8'h11 * (k + 1)), queueByte)
        end
        @(posedge clk_sys);
        queuePop <= 1'h0;
        #1;
        `CHK("queueValid", 1'h0, queueValid)
        apb(1'h1, 8'h2C, 32'h00800000, '0, 1'h0);
        fetch(32'h00000080, 32'h0BADF00D, 1'h0);
        apb(1'h0, 8'h80, '0, 32'h00000004, 1'h0);
        @(posedge clk_sys);
        #1;
        `CHK("lookupHit", 1'h0, lookupHit)
        apb(1'h1, 8'h2C, 32'h00000000, '0, 1'h0);
        @(posedge clk_sys);
        lookupAddr <= 32'h00000080;
        #1;
        `CHK("lookupHit", 1'h1, lookupHit)
        @(posedge clk_sys);
        {processLoad, lookupAddr} <= {1'h1, 32'h00000040};
        #1;
        `CHK("lookupHit", 1'h0, lookupHit)
        @(posedge clk_sys);
        processLoad <= 1'h0;
        @(posedge clk_sys);
        #1;
        `CHK("lookupHit", 1'h0, lookupHit)
    endtask
    task automatic t_ext;
        logic [31:0] xv [5] = '{32'h80, 32'hFFFFFF80, 32'h8080, 32'hFFFF8080, 32'h12348080};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys);
            {extIn, extSize, extSigned} <= {32'h12348080, i[2] ? 2'h2 : {1'h0, i[1]}, i[0]};
            @(posedge clk_sys);
            #1;
            `CHK("extOut", xv[i], extOut)
        end
        @(posedge clk_sys);
        operandIdx <= csrf_pkg::IDX_PC;
        #1;
        `CHK("operandIllegal", 1'h1, operandIllegal)
    endtask
    task automatic t_priv;
        apb(1'h1, 8'h2C, 32'h00001800, '0, 1'h0);
        @(posedge clk_sys);
        {coreWrEn, coreWrIdx, coreWrData} <= {1'h1, 5'h1F, 32'hDEAD0000};
        @(posedge clk_sys);
        coreWrEn <= 1'h0;
        #1;
        `CHK("privViolation", 1'h1, privViolation)
        apb(1'h1, 8'h7C, 32'h00001234, '0, 1'h1);
        #1;
        `CHK("privViolation", 1'h1, privViolation)
        apb(1'h0, 8'h7C, '0, 32'h0000001F, 1'h0);
        apb(1'h0, 8'h2C, '0, 32'h0000187B, 1'h0);
        coreRdIdx <= csrf_pkg::IDX_PSW;
        @(posedge clk_sys);
        #1;
        `CHK("coreRdData", 32'h0000187B, coreRdData)
    endtask
    task automatic report_and_stop;
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // the whole run needs under two hundred cycles; fifty times that means a hang
    initial begin
        #400000;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'h0;
        t_regs();
        t_psw();
        t_fetch();
        t_ext();
        t_priv();
        report_and_stop();
    end
endmodule
`default_nettype wire
